// ### rtl/pio_pkg.sv
// Constants and carrier types for the parallel port block
package pio_pkg;

    localparam int unsigned PIO_PORT_W       = 8;
    localparam int unsigned PIO_APB_AW       = 12;
    localparam int unsigned PIO_APB_DW       = 32;

    // Register indices; byte address is four times the index
    localparam logic [2:0]  PIO_IDX_A_PINS   = 3'h0;
    localparam logic [2:0]  PIO_IDX_B_PINS   = 3'h1;
    localparam logic [2:0]  PIO_IDX_C_PINS   = 3'h2;
    localparam logic [2:0]  PIO_IDX_D_PINS   = 3'h3;
    localparam logic [2:0]  PIO_IDX_A_DIR    = 3'h4;
    localparam logic [2:0]  PIO_IDX_B_DIR    = 3'h5;
    localparam logic [2:0]  PIO_IDX_C_DIR    = 3'h6;

    // Address split: word index field and decoded upper range
    localparam int unsigned PIO_IDX_LSB      = 2;
    localparam int unsigned PIO_IDX_MSB      = 4;

    // Direction reset: every pin an input
    localparam logic [7:0]  PIO_DIR_RESET    = 8'h00;
    localparam logic [31:0] PIO_RDATA_RESET  = 32'h0000_0000;

    // Input-only port field positions by shared serial unit
    localparam int unsigned PIO_TWO_WIRE_LSB = 6;
    localparam int unsigned PIO_SYNC_SER_LSB = 2;
    localparam int unsigned PIO_ASYNC_SER_LSB = 0;

    // Input synchroniser depth
    localparam int unsigned PIO_SYNC_STAGES  = 3;

    typedef struct packed {
        logic [7:0] port_a_pins;
        logic [7:0] port_b_pins;
        logic [7:0] port_c_pins;
    } pio_pins_t;

    typedef struct packed {
        logic [1:0] inputPortBitsTwoWire;
        logic [3:0] inputPortBitsSyncSerial;
        logic [1:0] inputPortBitsAsyncSerial;
    } pio_serial_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } pio_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pio_apb_rsp_t;

endpackage

// ### rtl/pio_pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pio_pin_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] pinRaw,
    output logic      [WIDTH-1:0] pinStable
);
    import pio_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage3;
        logic [WIDTH-1:0] stable;
    } pio_sync_state_t;

    pio_sync_state_t st_ff;
    pio_sync_state_t nxt_st;

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.stage1 = pinRaw;
        nxt_st.stage2 = st_ff.stage1;
        nxt_st.stage3 = st_ff.stage2;
        // A bit changes only once stages two and three agree
        for (int i = 0; i < WIDTH; i++) begin
            if (st_ff.stage2[i] == st_ff.stage3[i]) begin
                nxt_st.stable[i] = st_ff.stage3[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pinStable = st_ff.stable;

endmodule
`default_nettype wire

// ### rtl/pio_ports.sv
// Four parallel ports with APB register access
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pio_ports #(
    parameter int unsigned PORT_W = 8
) (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Bidirectional port pins
    input  wire pio_pkg::pio_pins_t    pinIn,
    output logic      [23:0]           pinOutBits,
    output logic      [23:0]           pinOeBits,
    // Input-only port and its serial users
    input  wire logic [PORT_W-1:0]     portDIn,
    output logic      [7:0]            serialTapBits
);
    import pio_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State

    typedef enum {
        PIO_BUS_IDLE,
        PIO_BUS_ANSWER
    } pio_bus_state_t;

    typedef struct packed {
        pio_bus_state_t busState;
        logic [7:0]     portAData;
        logic [7:0]     portBData;
        logic [7:0]     portCData;
        logic [7:0]     portDData;
        logic [7:0]     portADir;
        logic [7:0]     portBDir;
        logic [7:0]     portCDir;
        logic [31:0]    rdata;
        logic           ready;
        logic           slvErr;
    } pio_state_t;

    pio_state_t st_ff;
    pio_state_t nxt_st;

    ////////////////////////////////////////////////////////////////////
    // Pin input synchronisers

    pio_pins_t        pinSync;
    logic [PORT_W-1:0] portDSync;

    pio_pin_sync #(
        .WIDTH (8)
    ) u_sync_a (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .pinRaw    (pinIn.port_a_pins),
        .pinStable (pinSync.port_a_pins)
    );

    pio_pin_sync #(
        .WIDTH (8)
    ) u_sync_b (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .pinRaw    (pinIn.port_b_pins),
        .pinStable (pinSync.port_b_pins)
    );

    pio_pin_sync #(
        .WIDTH (8)
    ) u_sync_c (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .pinRaw    (pinIn.port_c_pins),
        .pinStable (pinSync.port_c_pins)
    );

    pio_pin_sync #(
        .WIDTH (PORT_W)
    ) u_sync_d (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .pinRaw    (portDIn),
        .pinStable (portDSync)
    );

    ////////////////////////////////////////////////////////////////////
    // Bus carriers

    pio_apb_req_t apbReq;
    pio_apb_rsp_t apbRsp;

    always_comb begin
        apbReq.psel    = psel;
        apbReq.penable = penable;
        apbReq.pwrite  = pwrite;
        apbReq.paddr   = paddr;
        apbReq.pwdata  = pwdata;
        apbReq.pstrb   = pstrb;
    end

    always_comb begin
        apbRsp.prdata  = st_ff.rdata;
        apbRsp.pready  = st_ff.ready;
        apbRsp.pslverr = st_ff.slvErr;
    end

    ////////////////////////////////////////////////////////////////////
    // Address decode

    logic [2:0] regIdx;
    logic       addrInRange;
    logic       isAccess;
    logic       isWrite;
    logic       lane0Write;

    always_comb begin
        regIdx      = apbReq.paddr[PIO_IDX_MSB:PIO_IDX_LSB];
        // Word-aligned, inside the seven-word window
        addrInRange = (apbReq.paddr[1:0] == 2'b00)
                   && (apbReq.paddr[11:PIO_IDX_MSB+1] == '0)
                   && (regIdx <= PIO_IDX_C_DIR);
        isAccess    = apbReq.psel && apbReq.penable;
        isWrite     = isAccess && apbReq.pwrite && st_ff.ready;
        lane0Write  = isWrite && apbReq.pstrb[0] && addrInRange;
    end

    ////////////////////////////////////////////////////////////////////
    // Write strobes, one per writable register

    typedef struct packed {
        logic aData;
        logic bData;
        logic cData;
        logic aDir;
        logic bDir;
        logic cDir;
    } pio_wr_en_t;

    pio_wr_en_t wrEn;

    always_comb begin
        wrEn       = '0;
        wrEn.aData = lane0Write && (regIdx == PIO_IDX_A_PINS);
        wrEn.bData = lane0Write && (regIdx == PIO_IDX_B_PINS);
        wrEn.cData = lane0Write && (regIdx == PIO_IDX_C_PINS);
        wrEn.aDir  = lane0Write && (regIdx == PIO_IDX_A_DIR);
        wrEn.bDir  = lane0Write && (regIdx == PIO_IDX_B_DIR);
        wrEn.cDir  = lane0Write && (regIdx == PIO_IDX_C_DIR);
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux

    function automatic logic [7:0] pinView(
        input logic [7:0] dataReg,
        input logic [7:0] dirReg,
        input logic [7:0] pinLevel
    );
        // Outputs show the latch, inputs show the pin
        pinView = (dataReg & dirReg) | (pinLevel & ~dirReg);
    endfunction

    logic [7:0] viewA;
    logic [7:0] viewB;
    logic [7:0] viewC;

    always_comb begin
        viewA = pinView(st_ff.portAData, st_ff.portADir, pinSync.port_a_pins);
        viewB = pinView(st_ff.portBData, st_ff.portBDir, pinSync.port_b_pins);
        viewC = pinView(st_ff.portCData, st_ff.portCDir, pinSync.port_c_pins);
    end

    logic [7:0] readByte;
    logic       readErr;

    always_comb begin
        readByte = '0;
        readErr  = 1'b0;
        case (regIdx)
            PIO_IDX_A_PINS: begin
                readByte = viewA;
            end
            PIO_IDX_B_PINS: begin
                readByte = viewB;
            end
            PIO_IDX_C_PINS: begin
                readByte = viewC;
            end
            PIO_IDX_D_PINS: begin
                readByte = st_ff.portDData;
            end
            PIO_IDX_A_DIR: begin
                readByte = st_ff.portADir;
            end
            PIO_IDX_B_DIR: begin
                readByte = st_ff.portBDir;
            end
            PIO_IDX_C_DIR: begin
                readByte = st_ff.portCDir;
            end
            default: begin
                readErr  = 1'b1;
            end
        endcase
        if (!addrInRange) begin
            readByte = '0;
            readErr  = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Answer to the access now seen

    logic        wrRefused;
    logic        ansErr;
    logic [31:0] ansData;

    always_comb begin
        // Writes to the input-only port are refused
        wrRefused = apbReq.pwrite && (regIdx == PIO_IDX_D_PINS);
        ansErr    = readErr || wrRefused;
        ansData   = apbReq.pwrite ? PIO_RDATA_RESET : {24'h00_0000, readByte};
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_st = st_ff;

        // Input-only port samples its pins every cycle
        nxt_st.portDData = portDSync[7:0];

        case (st_ff.busState)
            PIO_BUS_IDLE: begin
                nxt_st.ready  = 1'b0;
                nxt_st.slvErr = 1'b0;
                if (isAccess) begin
                    // One wait state so the answer leaves a flop
                    nxt_st.busState = PIO_BUS_ANSWER;
                    nxt_st.ready    = 1'b1;
                    nxt_st.slvErr   = ansErr;
                    nxt_st.rdata    = ansData;
                end
            end
            PIO_BUS_ANSWER: begin
                nxt_st.busState = PIO_BUS_IDLE;
                nxt_st.ready    = 1'b0;
                nxt_st.slvErr   = 1'b0;
                nxt_st.rdata    = PIO_RDATA_RESET;
            end
            default: begin
                nxt_st.busState = PIO_BUS_IDLE;
                nxt_st.ready    = 1'b0;
                nxt_st.slvErr   = 1'b0;
            end
        endcase

        // Writes land at the completing edge only
        if (wrEn.aData) begin
            nxt_st.portAData = apbReq.pwdata[7:0];
        end
        if (wrEn.bData) begin
            nxt_st.portBData = apbReq.pwdata[7:0];
        end
        if (wrEn.cData) begin
            nxt_st.portCData = apbReq.pwdata[7:0];
        end
        if (wrEn.aDir) begin
            nxt_st.portADir = apbReq.pwdata[7:0];
        end
        if (wrEn.bDir) begin
            nxt_st.portBDir = apbReq.pwdata[7:0];
        end
        if (wrEn.cDir) begin
            nxt_st.portCDir = apbReq.pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            // Directions forced to input; data latches untouched
            st_ff.portADir <= PIO_DIR_RESET;
            st_ff.portBDir <= PIO_DIR_RESET;
            st_ff.portCDir <= PIO_DIR_RESET;
            st_ff.busState <= PIO_BUS_IDLE;
            st_ff.rdata    <= PIO_RDATA_RESET;
            st_ff.ready    <= 1'b0;
            st_ff.slvErr   <= 1'b0;
        end else begin
            st_ff          <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata  = apbRsp.prdata;
    assign pready  = apbRsp.pready;
    assign pslverr = apbRsp.pslverr;

    // Pins A to C carry only the port latch, no other function
    assign pinOutBits = {st_ff.portAData, st_ff.portBData, st_ff.portCData};
    assign pinOeBits  = {st_ff.portADir, st_ff.portBDir, st_ff.portCDir};

    // Serial units see the input-only port in three groups
    pio_serial_t serialTap;

    always_comb begin
        serialTap.inputPortBitsTwoWire     = st_ff.portDData[PIO_TWO_WIRE_LSB +: 2];
        serialTap.inputPortBitsSyncSerial  = st_ff.portDData[PIO_SYNC_SER_LSB +: 4];
        serialTap.inputPortBitsAsyncSerial = st_ff.portDData[PIO_ASYNC_SER_LSB +: 2];
    end

    assign serialTapBits = serialTap;

endmodule
`default_nettype wire

// ### sim/pio_ports_assertions.sv
// Concurrent checks on the parallel port bus and pin controls
`timescale 1ns/1ps
`default_nettype none
module pio_ports_assertions (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [23:0] pinOutBits,
    input wire logic [23:0] pinOeBits
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic       wr;
    logic [7:0] wByte;
    assign wr    = psel & penable & pready & pwrite & pstrb[0] & ~pslverr;
    assign wByte = pwdata[7:0];
    ////////////////////////////////////////////////////////////////
    a_ready_after_access: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after access");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    a_rdata_byte_only: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    a_input_port_ro: assert property (pready && pwrite && paddr == 12'h00C |-> pslverr)
        else $error("input port write accepted");
    a_dir_a_write: assert property (
        wr && paddr == 12'h010 |=> pinOeBits[23:16] == $past(wByte))
        else $error("port a direction wrong");
    a_dir_b_write: assert property (
        wr && paddr == 12'h014 |=> pinOeBits[15:8] == $past(wByte))
        else $error("port b direction wrong");
    a_dir_c_write: assert property (
        wr && paddr == 12'h018 |=> pinOeBits[7:0] == $past(wByte))
        else $error("port c direction wrong");
    a_data_a_write: assert property (
        wr && paddr == 12'h000 |=> pinOutBits[23:16] == $past(wByte))
        else $error("port a data wrong");
    a_oe_only_by_write: assert property (
        !(pready && pwrite) |=> $stable(pinOeBits))
        else $error("direction changed without write");
    a_reset_all_inputs: assert property (
        disable iff (1'b0) !resetn |-> pinOeBits == 24'h00_0000)
        else $error("pin driven in reset");
endmodule
`default_nettype wire

// ### sim/pio_pins_model.sv
// Board side of the bidirectional pins: device driver or board driver
`timescale 1ns/1ps
`default_nettype none
module pio_pins_model (
    input  wire logic [23:0]   pinOutBits,
    input  wire logic [23:0]   pinOeBits,
    input  wire logic [23:0]   extLevel,
    output var pio_pkg::pio_pins_t pinIn
);
    import pio_pkg::*;
    // Board driver backs off wherever the device drives
    assign pinIn = pio_pins_t'((pinOutBits & pinOeBits) | (extLevel & ~pinOeBits));
endmodule
`default_nettype wire

// ### sim/parallel_io_ports_tb_top.sv
// Self-checking bench for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module parallel_io_ports_tb_top;
    import pio_pkg::*;
    logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    pio_pins_t   pinIn;
    logic [23:0] pinOutBits, pinOeBits, extLevel;
    logic [7:0]  portDIn, serialTapBits;
    int          n_fail, checks;

    pio_ports u_pio_ports (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .pinIn, .pinOutBits, .pinOeBits, .portDIn,
        .serialTapBits);
    pio_pins_model u_pio_pins_model (.pinOutBits, .pinOeBits, .extLevel, .pinIn);
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        pstrb   <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic t_outputs;
        logic [7:0] d;
        for (int i = 0; i < 3; i++) begin
            d = 8'hA1 + 8'(i);
            extLevel[23-8*i -: 8] <= ~d;
            apb(1, 12'(4*i), d, 4'hF);
            apb(1, 12'(16+4*i), 8'hFF, 4'hF);
            check(pinOeBits[23-8*i -: 8], 8'hFF);
            check(pinOutBits[23-8*i -: 8], d);
            apb(0, 12'(4*i), 8'h00, 4'hF);
            check(rd, d);
            apb(0, 12'(16+4*i), 8'h00, 4'hF);
            check(rd, 8'hFF);
        end
    endtask

    task automatic t_mixed;
        apb(1, 12'h014, 8'h0F, 4'hF);
        extLevel[15:8] <= 8'h3C;
        repeat (8) @(posedge clk_sys);
        apb(0, 12'h004, 8'h00, 4'hF);
        check(rd, 8'h32);
        apb(1, 12'h008, 8'h55, 4'h0);
        check(pinOutBits[7:0], 8'hA3);
    endtask

    task automatic t_input_port;
        @(posedge clk_sys);
        portDIn <= 8'hC9;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        check(serialTapBits[7:6], 2'h3);
        check(serialTapBits[5:2], 4'h2);
        check(serialTapBits[1:0], 2'h1);
        apb(1, 12'h00C, 8'h00, 4'hF);
        check(er, 1'b1);
        apb(0, 12'h00C, 8'h00, 4'hF);
        check(rd, 8'hC9);
        apb(0, 12'h01C, 8'h00, 4'hF);
        check(er, 1'b1);
        check(rd, 32'h0000_0000);
        apb(0, 12'h001, 8'h00, 4'hF);
        check(er, 1'b1);
    endtask

    task automatic t_reset_mid;
        @(posedge clk_sys);
        resetn <= 1'b0;
        @(negedge clk_sys);
        check(pinOeBits, 24'h00_0000);
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        @(negedge clk_sys);
        check(pinOutBits, 24'hA1_A2A3);
        repeat (8) @(posedge clk_sys);
        for (int i = 0; i < 3; i++) begin
            apb(0, 12'(16+4*i), 8'h00, 4'hF);
            check(rd, 8'h00);
        end
        apb(0, 12'h00C, 8'h00, 4'hF);
        check(rd, 8'hC9);
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata, pstrb} <= '0;
        extLevel <= 24'h00_0000;
        portDIn  <= 8'h00;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        @(negedge clk_sys);
        check(pinOeBits, 24'h00_0000);
        t_outputs();
        t_mixed();
        t_input_port();
        t_reset_mid();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        report_and_stop();
    end
endmodule

bind pio_ports pio_ports_assertions u_pio_ports_assertions (.clk_sys, .resetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pinOutBits,
    .pinOeBits);
`default_nettype wire
